// ### design/sdc_sequencer.sv
`timescale 1ns/10ps
module sdc_sequencer
    import sdc_pkg::*;
#(
    parameter int CLOCK_INPUT_PIN_HALF = CLOCK_INPUT_PIN_HALF_CYC
)
(
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst_n,
    // Device pins
    input wire logic resetPinN,
    input wire logic serialClk,
    input wire logic chipSelN,
    input wire logic serialIn,
    output logic serialOut,
    output logic conversionReadyN,
    output logic clockOutputPin,
    // Filter result word
    input wire logic [15:0] sampleIn
);
    sdc_clk_if cif ();
    sdc_state_t state_reg;
    logic regReset;
    logic sclkPrev_reg;
    logic [4:0] bitCnt_reg;
    logic [4:0] xferLen_reg;
    logic [23:0] shiftIn_reg;
    logic [23:0] shiftOut_reg;
    logic dataPhase_reg;
    logic [7:0] comm_reg;
    logic [7:0] setup_reg;
    logic [5:0] clkCtl_reg;
    logic [15:0] data_reg;
    logic [23:0] offReg [3];
    logic [23:0] gainReg [3];
    logic [23:0] activeOff_reg;
    logic [23:0] activeGain_reg;
    logic [1:0] calMode_reg;
    logic [1:0] calPair_reg;
    logic afterCal_reg;
    logic [3:0] periodsLeft_reg;
    logic [15:0] odrCnt_reg;
    logic [11:0] pipeCnt_reg;
    logic [11:0] blankCnt_reg;
    logic sclkRise;
    logic sclkFall;
    logic xferDone;
    logic [23:0] inWord;
    logic [2:0] rsSel;
    logic [1:0] pair;
    logic wrSetup;
    logic wrClock;
    logic wrOff;
    logic wrGain;
    logic dataReadDone;
    logic startEvt;
    logic periodEnd;
    logic calDone;
    logic resultNow;
    logic [15:0] periodLen;
    logic [4:0] lenSel;
    logic [23:0] readWord;
    logic [15:0] diff;
    logic [31:0] prod;

    sdc_timebase #(.CLOCK_INPUT_PIN_HALF(CLOCK_INPUT_PIN_HALF)) u_timebase (.clk(clk), .rst_n(rst_n), .tb(cif.gen));

    assign cif.intOsc = clkCtl_reg[CLK_OSC_BIT];
    assign cif.halve = clkCtl_reg[CLK_HALVE_BIT];
    assign cif.clock_output_disable = clkCtl_reg[CLK_DIS_BIT];
    assign clockOutputPin = cif.clkOutPin;
    assign regReset = !rst_n || !resetPinN;

    // ----------------------------------------
    // Serial port
    // ----------------------------------------
    assign sclkRise = serialClk && !sclkPrev_reg && !chipSelN && !regReset;
    assign sclkFall = !serialClk && sclkPrev_reg && !chipSelN && !regReset;
    assign xferDone = sclkRise && (bitCnt_reg + 5'd1 == xferLen_reg);
    assign inWord = {shiftIn_reg[22:0], serialIn};
    assign rsSel = comm_reg[6:4];
    assign pair = (comm_reg[1:0] == 2'h3) ? 2'h2 : {1'b0, comm_reg[1:0] == 2'h1};
    assign wrSetup = xferDone && dataPhase_reg && !comm_reg[COMM_RW_BIT] && rsSel == RS_SETUP;
    assign wrClock = xferDone && dataPhase_reg && !comm_reg[COMM_RW_BIT] && rsSel == RS_CLOCK;
    assign wrOff = xferDone && dataPhase_reg && !comm_reg[COMM_RW_BIT] && rsSel == RS_OFFSET;
    assign wrGain = xferDone && dataPhase_reg && !comm_reg[COMM_RW_BIT] && rsSel == RS_GAIN;
    assign dataReadDone = xferDone && dataPhase_reg && comm_reg[COMM_RW_BIT] && rsSel == RS_DATA;

    always_comb
    begin
        lenSel = LEN_BYTE;
        readWord = {comm_reg, 16'h0000};
        case (inWord[6:4])
            RS_COMM: readWord = {conversionReadyN, inWord[6:0], 16'h0000};
            RS_SETUP: readWord = {setup_reg, 16'h0000};
            RS_CLOCK: readWord = {MAKER_ID_VAL, 1'b0, clkCtl_reg, 16'h0000};
            RS_DATA:
            begin
                lenSel = LEN_WORD;
                readWord = {data_reg, 8'h00};
            end
            RS_OFFSET:
            begin
                lenSel = LEN_COEF;
                readWord = offReg[(inWord[1:0] == 2'h3) ? 2'h2 : {1'b0, inWord[1:0] == 2'h1}];
            end
            RS_GAIN:
            begin
                lenSel = LEN_COEF;
                readWord = gainReg[(inWord[1:0] == 2'h3) ? 2'h2 : {1'b0, inWord[1:0] == 2'h1}];
            end
            default: readWord = 24'h000000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (regReset)
        begin
            sclkPrev_reg <= 1'b0;
            bitCnt_reg <= 5'd0;
            xferLen_reg <= LEN_BYTE;
            shiftIn_reg <= 24'h000000;
            shiftOut_reg <= 24'h000000;
            serialOut <= 1'b0;
            dataPhase_reg <= 1'b0;
            comm_reg <= 8'h00;
        end
        else
        begin
            sclkPrev_reg <= serialClk;
            if (chipSelN)
                bitCnt_reg <= 5'd0;
            else if (sclkRise)
            begin
                shiftIn_reg <= inWord;
                bitCnt_reg <= xferDone ? 5'd0 : bitCnt_reg + 5'd1;
            end
            if (xferDone && !dataPhase_reg && !inWord[COMM_ZERO_BIT])
            begin
                comm_reg <= inWord[7:0];
                dataPhase_reg <= (inWord[6:4] != RS_NOP);
                xferLen_reg <= (inWord[6:4] == RS_NOP) ? LEN_BYTE : lenSel;
                shiftOut_reg <= {readWord[22:0], 1'b0};
                if (inWord[COMM_RW_BIT])
                    serialOut <= readWord[23];
            end
            else if (xferDone && dataPhase_reg)
            begin
                dataPhase_reg <= 1'b0;
                xferLen_reg <= LEN_BYTE;
            end
            else if (sclkFall && dataPhase_reg && comm_reg[COMM_RW_BIT] && bitCnt_reg != 5'd0)
            begin
                serialOut <= shiftOut_reg[23];
                shiftOut_reg <= {shiftOut_reg[22:0], 1'b0};
            end
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (regReset)
        begin
            setup_reg <= SETUP_RST;
            clkCtl_reg <= CLKCTL_RST;
        end
        else
        begin
            if (wrSetup)
                setup_reg <= inWord[7:0];
            else if (calDone)
                setup_reg[7:6] <= MODE_NORMAL;
            if (wrClock)
                clkCtl_reg <= inWord[5:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_pair
            always_ff @(posedge clk)
            begin
                if (regReset)
                begin
                    offReg[gi] <= OFFSET_RST;
                    gainReg[gi] <= GAIN_RST;
                end
                else
                begin
                    if (wrOff && pair == 2'(gi))
                        offReg[gi] <= inWord;
                    else if (calDone && calPair_reg == 2'(gi) && calMode_reg != MODE_FULL)
                        offReg[gi] <= {sampleIn, 8'h00};
                    if (wrGain && pair == 2'(gi))
                        gainReg[gi] <= inWord;
                    else if (calDone && calPair_reg == 2'(gi) && calMode_reg != MODE_ZERO)
                        gainReg[gi] <= {sampleIn, 8'h00};
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    assign periodLen = 16'({7'h00, sdc_decim(clkCtl_reg[CLK_RATE_BIT], clkCtl_reg[1:0])} * {8'h00, MOD_CYCLE});
    assign periodEnd = cif.modTick && (odrCnt_reg == periodLen - 16'h0001);
    assign startEvt = wrSetup && !inWord[SETUP_SYNC_BIT]
        && (setup_reg[SETUP_SYNC_BIT] || inWord[7:6] != MODE_NORMAL);
    assign calDone = state_reg == ST_CAL && periodEnd && periodsLeft_reg == 4'd1;
    assign resultNow = ((state_reg == ST_FIRST && periodEnd && periodsLeft_reg == 4'd1 && !afterCal_reg)
        || (state_reg == ST_PIPE && cif.clkinTick && pipeCnt_reg == 12'd0)
        || (state_reg == ST_RUN && periodEnd)) && !(wrSetup && inWord[SETUP_SYNC_BIT]);

    always_ff @(posedge clk)
    begin
        if (regReset)
        begin
            state_reg <= ST_HOLD;
            periodsLeft_reg <= 4'd0;
            pipeCnt_reg <= 12'd0;
            calMode_reg <= MODE_NORMAL;
            calPair_reg <= 2'h0;
            afterCal_reg <= 1'b0;
        end
        else if (wrSetup && inWord[SETUP_SYNC_BIT])
            state_reg <= ST_HOLD;
        else if (startEvt)
        begin
            calMode_reg <= inWord[7:6];
            calPair_reg <= pair;
            afterCal_reg <= (inWord[7:6] != MODE_NORMAL);
            state_reg <= (inWord[7:6] != MODE_NORMAL) ? ST_CAL : ST_FIRST;
            case (inWord[7:6])
                MODE_NORMAL: periodsLeft_reg <= NORM_PERIODS;
                MODE_SELF: periodsLeft_reg <= SELF_CAL_PERIODS;
                default: periodsLeft_reg <= SYS_CAL_PERIODS;
            endcase
        end
        else
        begin
            case (state_reg)
                ST_CAL:
                    if (periodEnd)
                    begin
                        periodsLeft_reg <= periodsLeft_reg - 4'd1;
                        if (calDone)
                        begin
                            state_reg <= ST_FIRST;
                            periodsLeft_reg <= (calMode_reg == MODE_SELF) ? SELF_CONV_PERIODS : SYS_CONV_PERIODS;
                        end
                    end
                ST_FIRST:
                    if (periodEnd)
                    begin
                        periodsLeft_reg <= periodsLeft_reg - 4'd1;
                        if (periodsLeft_reg == 4'd1)
                        begin
                            state_reg <= afterCal_reg ? ST_PIPE : ST_RUN;
                            pipeCnt_reg <= PIPE_TICKS - 12'd1;
                        end
                    end
                ST_PIPE:
                    if (cif.clkinTick)
                    begin
                        pipeCnt_reg <= pipeCnt_reg - 12'd1;
                        if (pipeCnt_reg == 12'd0)
                            state_reg <= ST_RUN;
                    end
                ST_HOLD: periodsLeft_reg <= 4'd0;
                ST_RUN: periodsLeft_reg <= 4'd0;
                default: state_reg <= ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (regReset || startEvt || state_reg == ST_HOLD || state_reg == ST_PIPE)
            odrCnt_reg <= 16'h0000;
        else if (cif.modTick)
            odrCnt_reg <= periodEnd ? 16'h0000 : odrCnt_reg + 16'h0001;
    end

    // ----------------------------------------
    // Result path
    // ----------------------------------------
    assign diff = sampleIn - activeOff_reg[23:8];
    assign prod = {16'h0000, diff} * {16'h0000, activeGain_reg[23:8]};

    always_ff @(posedge clk)
    begin
        if (regReset)
        begin
            activeOff_reg <= OFFSET_RST;
            activeGain_reg <= GAIN_RST;
            data_reg <= 16'h0000;
        end
        else
        begin
            if (startEvt || resultNow)
            begin
                activeOff_reg <= offReg[pair];
                activeGain_reg <= gainReg[pair];
            end
            if (resultNow)
                data_reg <= prod[30:15];
        end
    end

    // ----------------------------------------
    // Ready output
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (regReset)
        begin
            conversionReadyN <= 1'b1;
            blankCnt_reg <= 12'd0;
        end
        else if (resultNow)
        begin
            conversionReadyN <= !conversionReadyN;
            blankCnt_reg <= conversionReadyN ? 12'd0 : BLANK_TICKS;
        end
        else if (startEvt)
        begin
            conversionReadyN <= 1'b1;
            blankCnt_reg <= 12'd0;
        end
        else if (blankCnt_reg != 12'd0)
        begin
            if (cif.clkinTick)
            begin
                blankCnt_reg <= blankCnt_reg - 12'd1;
                if (blankCnt_reg == 12'd1)
                    conversionReadyN <= 1'b0;
            end
        end
        else if (dataReadDone)
            conversionReadyN <= 1'b1;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (regReset);

    chk_reset_ready: assert property (@(posedge clk) disable iff (!rst_n) !resetPinN |=> conversionReadyN)
        else $error("ready not high under reset pin");
    chk_sync_hold: assert property (wrSetup && inWord[SETUP_SYNC_BIT] |=> (state_reg == ST_HOLD) [*2])
        else $error("filter-sync high did not hold sequencer");
    chk_unread_blank: assert property (resultNow && !conversionReadyN |=> conversionReadyN && blankCnt_reg == 12'd500)
        else $error("unread result did not blank ready");
    chk_read_clears: assert property (dataReadDone && !resultNow && blankCnt_reg == 12'd0 |=> conversionReadyN)
        else $error("data read did not raise ready");
    chk_mode_clear: assert property (calDone && !wrSetup |=> setup_reg[7:6] == 2'h0)
        else $error("mode field not cleared at calibration end");
    chk_sync_keeps: assert property ($rose(setup_reg[0]) && $past(!conversionReadyN)
        |-> !conversionReadyN)
        else $error("ready raised by filter-sync");
    chk_decim_table: assert property (!clkCtl_reg[2] && clkCtl_reg[1:0] == 2'h0 |-> periodLen == 16'd50048)
        else $error("decimation table wrong");
    chk_pipe_len: assert property ($rose(state_reg == ST_PIPE) |-> pipeCnt_reg == 12'd1999)
        else $error("pipeline delay not loaded");
    chk_first_count: assert property (startEvt && inWord[7:6] == 2'h0 |=> periodsLeft_reg == 4'd3 && state_reg == ST_FIRST)
        else $error("normal start not three periods");
    chk_clock_output_pin_off: assert property (@(posedge clk) disable iff (!rst_n) cif.clock_output_disable |=> !clockOutputPin)
        else $error("clock output not held low");
    cov_result: cover property (resultNow && conversionReadyN);
    cov_blank: cover property (resultNow && !conversionReadyN);
    cov_cal_done: cover property (calDone && calMode_reg == 2'h1);
    cov_read_done: cover property (dataReadDone);
endmodule

// ### design/sdc_pkg.sv
package sdc_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLOCK_INPUT_PIN_PERIOD_NS = 1000;
    localparam int CLOCK_INPUT_PIN_HALF_CYC = (CLOCK_INPUT_PIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    localparam logic [7:0] MOD_CYCLE = 8'd128;
    localparam logic [11:0] PIPE_TICKS = 12'd2000;
    localparam logic [11:0] BLANK_TICKS = 12'd500;
    localparam logic [3:0] NORM_PERIODS = 4'd3;
    localparam logic [3:0] SELF_CAL_PERIODS = 4'd6;
    localparam logic [3:0] SELF_CONV_PERIODS = 4'd3;
    localparam logic [3:0] SYS_CAL_PERIODS = 4'd3;
    localparam logic [3:0] SYS_CONV_PERIODS = 4'd1;
    // ----------------------------------------
    // Register selection and sizes
    // ----------------------------------------
    localparam logic [2:0] RS_COMM = 3'h0;
    localparam logic [2:0] RS_SETUP = 3'h1;
    localparam logic [2:0] RS_CLOCK = 3'h2;
    localparam logic [2:0] RS_DATA = 3'h3;
    localparam logic [2:0] RS_TEST = 3'h4;
    localparam logic [2:0] RS_NOP = 3'h5;
    localparam logic [2:0] RS_OFFSET = 3'h6;
    localparam logic [2:0] RS_GAIN = 3'h7;
    localparam logic [4:0] LEN_BYTE = 5'd8;
    localparam logic [4:0] LEN_WORD = 5'd16;
    localparam logic [4:0] LEN_COEF = 5'd24;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int COMM_ZERO_BIT = 7;
    localparam int COMM_RW_BIT = 3;
    localparam int COMM_PD_BIT = 2;
    localparam int SETUP_SYNC_BIT = 0;
    localparam int CLK_OSC_BIT = 5;
    localparam int CLK_DIS_BIT = 4;
    localparam int CLK_HALVE_BIT = 3;
    localparam int CLK_RATE_BIT = 2;
    localparam logic [7:0] SETUP_RST = 8'h01;
    localparam logic [5:0] CLKCTL_RST = 6'h05;
    // Arbitrary value for the maker identifier bit.
    localparam logic MAKER_ID_VAL = 1'b0;
    localparam logic [23:0] OFFSET_RST = 24'h1f4000;
    localparam logic [23:0] GAIN_RST = 24'h5761ab;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SELF = 2'h1;
    localparam logic [1:0] MODE_ZERO = 2'h2;
    localparam logic [1:0] MODE_FULL = 2'h3;

    typedef enum logic [2:0] {
        ST_HOLD = 3'h0,
        ST_CAL = 3'h1,
        ST_FIRST = 3'h3,
        ST_PIPE = 3'h2,
        ST_RUN = 3'h6
    } sdc_state_t;

    // Decimation rate from rate select and filter code.
    function automatic logic [8:0] sdc_decim(input logic rateSel, input logic [1:0] fsel);
        logic [8:0] d;
        d = 9'd0;
        case ({rateSel, fsel})
            3'h0: d = 9'd391;
            3'h1: d = 9'd313;
            3'h2: d = 9'd78;
            3'h3: d = 9'd39;
            3'h4: d = 9'd384;
            3'h5: d = 9'd320;
            3'h6: d = 9'd77;
            default: d = 9'd38;
        endcase
        return d;
    endfunction
endpackage

// ### design/sdc_clk_if.sv
`timescale 1ns/10ps
interface sdc_clk_if;
    logic intOsc;
    logic halve;
    logic clock_output_disable;
    logic clkinTick;
    logic modTick;
    logic clkOutPin;
    modport gen (input intOsc, input halve, input clock_output_disable, output clkinTick, output modTick, output clkOutPin);
    modport user (output intOsc, output halve, output clock_output_disable, input clkinTick, input modTick, input clkOutPin);
endinterface

// ### design/sdc_timebase.sv
`timescale 1ns/10ps
module sdc_timebase
    import sdc_pkg::*;
#(
    parameter int CLOCK_INPUT_PIN_HALF = CLOCK_INPUT_PIN_HALF_CYC
)
(
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst_n,
    // Clock generator link
    sdc_clk_if.gen tb
);
    logic [15:0] divCnt_reg;
    logic level_reg;
    logic halvePhase_reg;
    logic halfTick;
    logic riseTick;

    assign halfTick = (divCnt_reg == 16'(CLOCK_INPUT_PIN_HALF - 1));
    assign riseTick = halfTick && !level_reg;

    // ----------------------------------------
    // Input clock generator, reset only at power-up
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            divCnt_reg <= 16'h0000;
            level_reg <= 1'b0;
        end
        else
        begin
            divCnt_reg <= halfTick ? 16'h0000 : divCnt_reg + 16'h0001;
            if (halfTick)
                level_reg <= !level_reg;
        end
    end

    // ----------------------------------------
    // Ticks and clock output
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            halvePhase_reg <= 1'b0;
            tb.clkinTick <= 1'b0;
            tb.modTick <= 1'b0;
            tb.clkOutPin <= 1'b0;
        end
        else
        begin
            if (riseTick)
                halvePhase_reg <= !halvePhase_reg;
            tb.clkinTick <= riseTick;
            tb.modTick <= riseTick && (!(tb.halve && !tb.intOsc) || halvePhase_reg);
            tb.clkOutPin <= !tb.clock_output_disable && level_reg;
        end
    end
endmodule

// ### dv/sdc_host_model.sv
`timescale 1ns/10ps
module sdc_host_model
(
    // Clock
    input wire logic clk,
    // Serial port
    output logic serialClk,
    output logic chipSelN,
    output logic serialIn,
    input wire logic serialOut
);
    initial
    begin
        serialClk = 1'b0;
        chipSelN = 1'b1;
        serialIn = 1'b1;
    end

    // Sends a command byte, then n data bits, MSB first, and captures read bits.
    task automatic access(input logic [7:0] comm, input logic [23:0] wd, input int n, output logic [23:0] rd);
        logic [31:0] sh;
        sh = {comm, wd << (24 - n)};
        rd = 24'h0;
        @(posedge clk);
        #1;
        chipSelN = 1'b0;
        for (int i = 0; i < 8 + n; i++)
        begin
            serialIn = sh[31 - i];
            if (i >= 8)
                rd = {rd[22:0], serialOut};
            serialClk = 1'b1;
            repeat (2) @(posedge clk);
            #1;
            serialClk = 1'b0;
            repeat (2) @(posedge clk);
            #1;
        end
        chipSelN = 1'b1;
        serialIn = ~serialIn;
    endtask
endmodule

// ### dv/sdc_sequencer_tb.sv
`timescale 1ns/10ps
module sdc_sequencer_tb;
    import sdc_pkg::*;
    localparam int HALF = 1;
    localparam int PER = 2 * HALF * 128 * 38;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic resetPinN = 1'b1;
    logic serialClk;
    logic chipSelN;
    logic serialIn;
    logic serialOut;
    logic conversionReadyN;
    logic clockOutputPin;
    logic [23:0] rd;
    logic [15:0] sampleIn = 16'h1234;
    int fails = 0;
    int check_count = 0;
    int n;

    always #5 clk = ~clk;

    sdc_sequencer #(.CLOCK_INPUT_PIN_HALF(HALF)) u_sdc_sequencer (.clk(clk), .rst_n(rst_n), .resetPinN(resetPinN),
        .serialClk(serialClk), .chipSelN(chipSelN), .serialIn(serialIn), .serialOut(serialOut),
        .conversionReadyN(conversionReadyN), .clockOutputPin(clockOutputPin), .sampleIn(sampleIn));
    sdc_host_model u_sdc_host_model (.clk(clk), .serialClk(serialClk), .chipSelN(chipSelN),
        .serialIn(serialIn), .serialOut(serialOut));

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("fails=%0d check_count=%0d", fails, check_count);
        if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic rw(input logic [2:0] rs, input logic rdb, input logic [23:0] wd, input int len);
        u_sdc_host_model.access({1'b0, rs, rdb, 3'b000}, wd, len, rd);
    endtask

    task automatic wait_ready(input logic lvl, input int lim);
        n = 0;
        while (conversionReadyN !== lvl && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic test_registers;
        check(conversionReadyN, 1'b1);
        rw(RS_CLOCK, 1'b1, 24'h0, 8);
        check(rd[7:0], 8'h05);
        rw(RS_SETUP, 1'b1, 24'h0, 8);
        check(rd[7:0], 8'h01);
        rw(RS_CLOCK, 1'b0, 24'hd0, 8);
        rw(RS_CLOCK, 1'b1, 24'h0, 8);
        check(rd[7:0], 8'h10);
        check(clockOutputPin, 1'b0);
        rw(RS_CLOCK, 1'b0, 24'h07, 8);
    endtask

    task automatic test_convert;
        rw(RS_SETUP, 1'b0, 24'h0, 8);
        repeat (3 * PER - 300) @(posedge clk);
        #1;
        check(conversionReadyN, 1'b1);
        wait_ready(1'b0, 600);
        check(conversionReadyN, 1'b0);
        rw(RS_COMM, 1'b1, 24'h0, 8);
        check(rd[7], 1'b0);
        rw(RS_DATA, 1'b1, 24'h0, 16);
        check(rd[15:0], 16'ha5d9);
        @(posedge clk);
        #1;
        check(conversionReadyN, 1'b1);
        rw(RS_DATA, 1'b1, 24'h0, 16);
        check(rd[15:0], 16'ha5d9);
        wait_ready(1'b0, PER + 200);
        wait_ready(1'b1, PER + 200);
        repeat (980) @(posedge clk);
        #1;
        check(conversionReadyN, 1'b1);
        repeat (40) @(posedge clk);
        #1;
        check(conversionReadyN, 1'b0);
        rw(RS_SETUP, 1'b0, 24'h01, 8);
        repeat (200) @(posedge clk);
        #1;
        check(conversionReadyN, 1'b0);
    endtask

    task automatic test_calibrate;
        sampleIn = 16'h2468;
        rw(RS_SETUP, 1'b0, 24'h80, 8);
        check(conversionReadyN, 1'b1);
        repeat (3 * PER - 300) @(posedge clk);
        #1;
        rw(RS_SETUP, 1'b1, 24'h0, 8);
        check(rd[7:0], 8'h80);
        repeat (600) @(posedge clk);
        #1;
        rw(RS_SETUP, 1'b1, 24'h0, 8);
        check(rd[7:0], 8'h00);
        rw(RS_OFFSET, 1'b1, 24'h0, 24);
        check(rd, 24'h246800);
        repeat (PER + 3000) @(posedge clk);
        #1;
        check(conversionReadyN, 1'b1);
        wait_ready(1'b0, 1000);
        check(conversionReadyN, 1'b0);
    endtask

    task automatic test_reset_pin;
        @(posedge clk);
        #1;
        resetPinN = 1'b0;
        n = 0;
        repeat (20)
        begin
            @(posedge clk);
            #1;
            n += clockOutputPin;
        end
        check(conversionReadyN, 1'b1);
        check(n > 0 && n < 20, 1'b1);
        resetPinN = 1'b1;
        repeat (2) @(posedge clk);
        rw(RS_SETUP, 1'b1, 24'h0, 8);
        check(rd[7:0], 8'h01);
        rw(RS_GAIN, 1'b0, 24'h654321, 24);
        rw(RS_GAIN, 1'b1, 24'h0, 24);
        check(rd, 24'h654321);
    endtask

    initial
    begin
        #1_000_000;
        fails++;
        stop_test();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge clk);
        test_registers();
        test_convert();
        test_calibrate();
        test_reset_pin();
        stop_test();
    end
endmodule
